// ==== verilog/ipf_defs.svh ====
// offsets, field positions and reset values for the interrupt priority fields
`ifndef IPF_DEFS_SVH
`define IPF_DEFS_SVH
`define IPF_ADDR_W        4
`define IPF_OFS_CTRL_A    4'h0
`define IPF_OFS_CTRL_B    4'h1
`define IPF_OFS_CTRL_C    4'h2
`define IPF_LVL_W         3
`define IPF_LVL_RESET     3'h4
`define IPF_LVL_OFF       3'h0
`define IPF_POS_HI        12
`define IPF_POS_MH        8
`define IPF_POS_ML        4
`define IPF_POS_LO        0
`define IPF_MASK_A        16'h7777
`define IPF_MASK_B        16'h0777
`define IPF_MASK_C        16'h7777
`define IPF_RESET_A       16'h4444
`define IPF_RESET_B       16'h0444
`define IPF_RESET_C       16'h4444
`endif

// ==== verilog/ipf_pkg.sv ====
// types for the interrupt priority fields
package ipf_pkg;
   typedef logic [2:0] ipf_level_t;
   typedef struct packed {
      logic [15:0] ctrl_a;
      logic [15:0] ctrl_b;
      logic [15:0] ctrl_c;
      logic [15:0] rdata;
   } ipf_state_t;
endpackage

// ==== verilog/ipf_gate.sv ====
// gates one source's request by its priority level
`include "ipf_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ipf_gate (
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [2:0] level_i,
   input  wire logic       req_i,
   output logic            req_o,
   output logic [2:0]      level_o
);
   typedef struct packed {
      logic       req;
      logic [2:0] level;
   } ipf_gate_state_t;
   ipf_gate_state_t s_q;
   ipf_gate_state_t s_d;
   always_comb begin
      s_d       = s_q;
      s_d.req   = req_i && (level_i != `IPF_LVL_OFF);
      s_d.level = (level_i != `IPF_LVL_OFF) ? level_i : `IPF_LVL_OFF;
   end
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign req_o   = s_q.req;
   assign level_o = s_q.level;
   a_off_blocks: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (level_i == 3'h0) |=> !req_o)
      else $error("disabled source still requests");
endmodule
`default_nettype wire

// ==== verilog/ipf_regs.sv ====
// interrupt priority field registers with per-source level outputs and arbitration
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`include "ipf_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ipf_regs #(
   parameter int NUM_SRC = 11
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 reset_n_i,
   input  wire logic [3:0]           addr_i,
   input  wire logic [15:0]          wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   input  wire logic [NUM_SRC-1:0]   req_i,
   output logic      [15:0]          rdata_o,
   output logic      [2:0]           timer_two_level_o,
   output logic      [2:0]           compare_two_level_o,
   output logic      [2:0]           capture_two_level_o,
   output logic      [2:0]           dma_ch0_done_level_o,
   output logic      [2:0]           dma_ch1_done_level_o,
   output logic      [2:0]           adc_done_level_o,
   output logic      [2:0]           uart_tx_level_o,
   output logic      [2:0]           compare_seven_level_o,
   output logic      [2:0]           compare_six_level_o,
   output logic      [2:0]           compare_five_level_o,
   output logic      [2:0]           capture_six_level_o,
   output logic      [NUM_SRC-1:0]   gated_req_o,
   output logic                      irq_valid_o,
   output logic      [3:0]           irq_src_o,
   output logic      [2:0]           irq_level_o
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic ipf_pkg::ipf_level_t fld(input logic [15:0] r, input int pos);
      fld = r[pos +: 3];
   endfunction

   ipf_pkg::ipf_state_t s_q;
   ipf_pkg::ipf_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d       = s_q;
      s_d.rdata = 16'h0000;
      if (wr_i) begin
         case (addr_i)
            `IPF_OFS_CTRL_A: s_d.ctrl_a = wdata_i & `IPF_MASK_A;
            `IPF_OFS_CTRL_B: s_d.ctrl_b = wdata_i & `IPF_MASK_B;
            `IPF_OFS_CTRL_C: s_d.ctrl_c = wdata_i & `IPF_MASK_C;
            default: ;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            `IPF_OFS_CTRL_A: s_d.rdata = s_q.ctrl_a & `IPF_MASK_A;
            `IPF_OFS_CTRL_B: s_d.rdata = s_q.ctrl_b & `IPF_MASK_B;
            `IPF_OFS_CTRL_C: s_d.rdata = s_q.ctrl_c & `IPF_MASK_C;
            default:         s_d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         s_q.ctrl_a <= `IPF_RESET_A;
         s_q.ctrl_b <= `IPF_RESET_B;
         s_q.ctrl_c <= `IPF_RESET_C;
         s_q.rdata  <= 16'h0000;
      end else begin
         s_q <= s_d;
      end
   end
   assign rdata_o = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // source order: 0 timer2, 1 cmp2, 2 cap2, 3 dma0, 4 dma1, 5 adc, 6 uart tx,
   // 7 cmp7, 8 cmp6, 9 cmp5, 10 cap6
   logic [2:0] lvl [NUM_SRC];
   logic [2:0] lvl_q [NUM_SRC];
   assign lvl[0]  = fld(s_q.ctrl_a, `IPF_POS_HI);
   assign lvl[1]  = fld(s_q.ctrl_a, `IPF_POS_MH);
   assign lvl[2]  = fld(s_q.ctrl_a, `IPF_POS_ML);
   assign lvl[3]  = fld(s_q.ctrl_a, `IPF_POS_LO);
   assign lvl[4]  = fld(s_q.ctrl_b, `IPF_POS_MH);
   assign lvl[5]  = fld(s_q.ctrl_b, `IPF_POS_ML);
   assign lvl[6]  = fld(s_q.ctrl_b, `IPF_POS_LO);
   assign lvl[7]  = fld(s_q.ctrl_c, `IPF_POS_HI);
   assign lvl[8]  = fld(s_q.ctrl_c, `IPF_POS_MH);
   assign lvl[9]  = fld(s_q.ctrl_c, `IPF_POS_ML);
   assign lvl[10] = fld(s_q.ctrl_c, `IPF_POS_LO);

   // level outputs are flopped in the gate, so they trail a write by two edges
   for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      ipf_gate u_gate (
         .core_clk_i (core_clk_i),
         .reset_n_i  (reset_n_i),
         .level_i    (lvl[g]),
         .req_i      (req_i[g]),
         .req_o      (gated_req_o[g]),
         .level_o    (lvl_q[g])
      );
   end

   // the register's next value feeds the level ports so they change on the same edge as the register, one edge after a write
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         timer_two_level_o     <= `IPF_LVL_RESET;
         compare_two_level_o   <= `IPF_LVL_RESET;
         capture_two_level_o   <= `IPF_LVL_RESET;
         dma_ch0_done_level_o  <= `IPF_LVL_RESET;
         dma_ch1_done_level_o  <= `IPF_LVL_RESET;
         adc_done_level_o      <= `IPF_LVL_RESET;
         uart_tx_level_o       <= `IPF_LVL_RESET;
         compare_seven_level_o <= `IPF_LVL_RESET;
         compare_six_level_o   <= `IPF_LVL_RESET;
         compare_five_level_o  <= `IPF_LVL_RESET;
         capture_six_level_o   <= `IPF_LVL_RESET;
      end else begin
         timer_two_level_o     <= fld(s_d.ctrl_a, `IPF_POS_HI);
         compare_two_level_o   <= fld(s_d.ctrl_a, `IPF_POS_MH);
         capture_two_level_o   <= fld(s_d.ctrl_a, `IPF_POS_ML);
         dma_ch0_done_level_o  <= fld(s_d.ctrl_a, `IPF_POS_LO);
         dma_ch1_done_level_o  <= fld(s_d.ctrl_b, `IPF_POS_MH);
         adc_done_level_o      <= fld(s_d.ctrl_b, `IPF_POS_ML);
         uart_tx_level_o       <= fld(s_d.ctrl_b, `IPF_POS_LO);
         compare_seven_level_o <= fld(s_d.ctrl_c, `IPF_POS_HI);
         compare_six_level_o   <= fld(s_d.ctrl_c, `IPF_POS_MH);
         compare_five_level_o  <= fld(s_d.ctrl_c, `IPF_POS_ML);
         capture_six_level_o   <= fld(s_d.ctrl_c, `IPF_POS_LO);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ties go to the lower source index, a fixed natural order
   logic [2:0] best_lvl;
   logic [3:0] best_src;
   always_comb begin
      best_lvl = 3'h0;
      best_src = 4'h0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (gated_req_o[i] && (lvl_q[i] > best_lvl)) begin
            best_lvl = lvl_q[i];
            best_src = 4'(i);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         irq_valid_o <= 1'b0;
         irq_src_o   <= 4'h0;
         irq_level_o <= 3'h0;
      end else begin
         irq_valid_o <= (best_lvl != 3'h0);
         irq_src_o   <= best_src;
         irq_level_o <= best_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_reset_value: assert property (@(posedge core_clk_i)
      !reset_n_i |=> (timer_two_level_o == 3'h4 && uart_tx_level_o == 3'h4))
      else $error("level not 100 after reset");
   a_gap_bits_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      $past(rd_i) |-> ((rdata_o & 16'h8888) == 16'h0000))
      else $error("gap bit read nonzero");
   a_b_upper_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      ($past(rd_i) && $past(addr_i) == 4'h1) |-> (rdata_o[15:11] == 5'h00))
      else $error("register b upper bits nonzero");
   a_a_timer_field: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h0) |=> (timer_two_level_o == $past(wdata_i[14:12])
                                    && dma_ch0_done_level_o == $past(wdata_i[2:0])))
      else $error("register a field map wrong");
   a_c_cap6_field: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h2) |=> (compare_seven_level_o == $past(wdata_i[14:12])
                                    && capture_six_level_o == $past(wdata_i[2:0])))
      else $error("register c field map wrong");
   a_level_seven: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h1 && wdata_i[2:0] == 3'h7) |=> (uart_tx_level_o == 3'h7))
      else $error("code 111 not level 7");
   a_level_one: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h1 && wdata_i[6:4] == 3'h1) |=> (adc_done_level_o == 3'h1))
      else $error("code 001 not level 1");
   // a third source may outrank both, so only the weaker one is ruled out
   a_win_highest: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (gated_req_o[0] && gated_req_o[6] && lvl_q[6] > lvl_q[0])
      |=> (irq_src_o != 4'h0 && irq_level_o >= $past(lvl_q[6])))
      else $error("lower level won arbitration");
   a_write_edge: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h0) ##1 !(wr_i && addr_i == 4'h0) |-> ##1
      (compare_two_level_o == $past(compare_two_level_o)))
      else $error("level moved without write");
   a_a_mid_fields: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h0) |=> (compare_two_level_o == $past(wdata_i[10:8])
                                    && capture_two_level_o == $past(wdata_i[6:4])))
      else $error("register a middle fields wrong");
   a_b_field_map: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h1) |=> (dma_ch1_done_level_o == $past(wdata_i[10:8])
                                    && adc_done_level_o == $past(wdata_i[6:4])))
      else $error("register b field map wrong");
   a_c_mid_fields: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (wr_i && addr_i == 4'h2) |=> (compare_six_level_o == $past(wdata_i[10:8])
                                    && compare_five_level_o == $past(wdata_i[6:4])))
      else $error("register c middle fields wrong");
   a_unmapped_read: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      ($past(rd_i) && $past(addr_i) > 4'h2) |-> (rdata_o == 16'h0000))
      else $error("unmapped index read nonzero");
   a_idle_no_valid: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !(|gated_req_o) |=> !irq_valid_o)
      else $error("request valid with nothing pending");
   a_seven_wins: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (gated_req_o[0] && lvl_q[0] == 3'h7) |=> (irq_src_o == 4'h0 && irq_level_o == 3'h7))
      else $error("level 7 on source 0 did not win");
   a_level_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !wr_i |=> ($stable(timer_two_level_o) && $stable(capture_six_level_o)))
      else $error("level changed with no write");
endmodule
`default_nettype wire

// ==== dv/ipf_src_model.sv ====
// request sources standing on the far side of the priority fields
`timescale 1ns/1ps
`default_nettype none
module ipf_src_model (
   input  wire logic        core_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        load_i,
   input  wire logic [10:0] pat_i,
   output logic      [10:0] req_o
);
   // flags are levels: held until the next load, so the gated result can settle
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         req_o <= 11'h000;
      end else if (load_i) begin
         req_o <= pat_i;
      end
   end
endmodule
`default_nettype wire

// ==== dv/ipf_regs_tb.sv ====
// self-checking bench for the interrupt priority field registers
`include "ipf_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ipf_regs_tb;
   logic        core_clk_i = 1'h0;
   logic        reset_n_i  = 1'h0;
   logic [3:0]  addr_i     = 4'h0;
   logic [15:0] wdata_i    = 16'h0000;
   logic        wr_i       = 1'h0;
   logic        rd_i       = 1'h0;
   logic        load       = 1'h0;
   logic [10:0] pat        = 11'h000;
   logic [10:0] req;
   logic [15:0] rdata;
   logic [2:0]  lv [0:10];
   logic [10:0] gated;
   logic        irq_v;
   logic [3:0]  irq_s;
   logic [2:0]  irq_l;
   logic [15:0] exp_r [0:3];
   int          err_total   = 0;
   int          comparisons = 0;

   ipf_src_model src (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .load_i(load), .pat_i(pat), .req_o(req));
   ipf_regs dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .req_i(req), .rdata_o(rdata), .timer_two_level_o(lv[0]),
      .compare_two_level_o(lv[1]), .capture_two_level_o(lv[2]), .dma_ch0_done_level_o(lv[3]),
      .dma_ch1_done_level_o(lv[4]), .adc_done_level_o(lv[5]), .uart_tx_level_o(lv[6]),
      .compare_seven_level_o(lv[7]), .compare_six_level_o(lv[8]), .compare_five_level_o(lv[9]),
      .capture_six_level_o(lv[10]), .gated_req_o(gated), .irq_valid_o(irq_v), .irq_src_o(irq_s),
      .irq_level_o(irq_l));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] mask_of(input int a);
      return a == 0 ? `IPF_MASK_A : a == 1 ? `IPF_MASK_B : a == 2 ? `IPF_MASK_C : 16'h0000;
   endfunction

   // source order follows the req_i bit order
   function automatic logic [2:0] lvl_of(input int i);
      if (i < 4) return exp_r[0][12-4*i +: 3];
      if (i < 7) return exp_r[1][24-4*i +: 3];
      return exp_r[2][40-4*i +: 3];
   endfunction

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input int a, input logic [15:0] d);
      @(posedge core_clk_i);
      addr_i  <= a[3:0];
      wdata_i <= d;
      wr_i    <= 1'h1;
      @(posedge core_clk_i);
      wr_i <= 1'h0;
      if (a < 3) exp_r[a] = d & mask_of(a);
      #1;
      for (int i = 0; i < 11; i++) chk("level", lv[i], lvl_of(i));
   endtask

   task automatic rd(input int a);
      @(posedge core_clk_i);
      addr_i <= a[3:0];
      rd_i   <= 1'h1;
      @(posedge core_clk_i);
      rd_i <= 1'h0;
      #1;
      chk("rdata", rdata, a < 3 ? exp_r[a] : 16'h0000);
   endtask

   task automatic arb(input logic [10:0] p);
      logic [10:0] g    = 11'h000;
      logic [2:0]  best = 3'h0;
      logic [3:0]  win  = 4'h0;
      @(posedge core_clk_i);
      load <= 1'h1;
      pat  <= p;
      @(posedge core_clk_i);
      load <= 1'h0;
      repeat (2) @(posedge core_clk_i);
      #1;
      for (int i = 0; i < 11; i++) begin
         g[i] = p[i] && lvl_of(i) != 3'h0;
         // strict compare keeps the lower index on a tie
         if (g[i] && lvl_of(i) > best) begin
            best = lvl_of(i);
            win  = i[3:0];
         end
      end
      chk("gated", gated, g);
      chk("valid", irq_v, g != 11'h000);
      if (g != 11'h000) begin
         chk("source", irq_s, win);
         chk("irq level", irq_l, best);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #4 core_clk_i = ~core_clk_i;
   end

   initial begin
      #400000;
      err_total++;
      summarize();
   end

   initial begin
      int          a;
      logic [15:0] d;
      void'($urandom(32'hFCCCF4D8));
      exp_r[0] = `IPF_RESET_A;
      exp_r[1] = `IPF_RESET_B;
      exp_r[2] = `IPF_RESET_C;
      repeat (8) @(posedge core_clk_i);
      reset_n_i <= 1'h1;
      for (int r = 0; r < 4; r++) rd(r);
      for (int i = 0; i < 11; i++) chk("reset level", lv[i], `IPF_LVL_RESET);
      $display("test reset values done");
      // all-ones and all-zeros first, then random words including the unmapped index
      for (int k = 0; k < 30; k++) begin
         a = k < 6 ? k % 3 : $urandom % 4;
         d = k < 3 ? 16'hFFFF : k < 6 ? 16'h0000 : 16'($urandom);
         wr(a, d);
         rd(a);
         rd($urandom % 4);
      end
      $display("test register access done");
      // reset again with written values standing, levels must fall back to 100
      @(posedge core_clk_i);
      reset_n_i <= 1'h0;
      repeat (2) @(posedge core_clk_i);
      reset_n_i <= 1'h1;
      exp_r[0] = `IPF_RESET_A;
      exp_r[1] = `IPF_RESET_B;
      exp_r[2] = `IPF_RESET_C;
      for (int r = 0; r < 3; r++) rd(r);
      for (int i = 0; i < 11; i++) chk("mid reset level", lv[i], `IPF_LVL_RESET);
      $display("test mid-run reset done");
      // every code on every source at once, each with all requests up, then random mixes
      for (int k = 0; k < 24; k++) begin
         d = k < 8 ? {4{1'h0, k[2:0]}} : 16'($urandom);
         for (int r = 0; r < 3; r++) wr(r, d);
         arb(k < 8 ? 11'h7FF : 11'($urandom));
      end
      $display("test arbitration done");
      summarize();
   end
endmodule
`default_nettype wire
